// ==== port_a_upper_pin_control.v ====
// Contract
// RULE1: Lines four, six, seven: input or push-pull output.
// RULE2: Line five output is open drain only.
// RULE3: Line five may be reset input or PWM.
// RULE4: Input enable low blocks input and wake.
// RULE5: Software clears input enable on analog pins.
// RULE6: Enabled pin level change ends sleep.
// RULE7: Crystal mode gives lines seven and six away.
// RULE8: Line four: comparator, LCD bias or PWM.
// RULE9: Wake-up speed selectable, normal or fast.
// RULE10: Port drive selectable, normal or low.
// RULE11: Every pin has pull-up and wake capability.
// RULE12: Alternate output function overrides port data.
`include "port_a_upper_defines.vh"

module port_a_upper_pin_control #(
    parameter WAKE_NORMAL_CYCLES = `WAKE_NORMAL_CYCLES
) (
    input  wire       clock,
    input  wire       nrst,
    // Software configuration.
    input  wire [3:0] port_out_data,
    input  wire [3:0] port_direction_out,
    input  wire [3:0] port_pullup_enable,
    input  wire [3:0] port_input_enable,
    input  wire       wake_speed_fast,
    input  wire       drive_low_select,
    input  wire       external_crystal_oscillator,
    input  wire       hardware_reset_enable,
    input  wire       line_five_pwm_enable,
    input  wire       line_four_pwm_enable,
    input  wire       lcd_common_three_enable,
    input  wire       comparator_positive_select,
    input  wire       comparator_negative_select,
    input  wire       sleep_request,
    // Alternate function sources.
    input  wire       pwm_gen_two_output,
    input  wire       pwm_gen_one_output,
    // Package pins.
    input  wire       port_a_line_four_in,
    output reg        port_a_line_four_out,
    output reg        port_a_line_four_oe_n,
    input  wire       port_a_line_five_in,
    output reg        port_a_line_five_out,
    output reg        port_a_line_five_oe_n,
    input  wire       port_a_line_six_in,
    output reg        port_a_line_six_out,
    output reg        port_a_line_six_oe_n,
    input  wire       port_a_line_seven_in,
    output reg        port_a_line_seven_out,
    output reg        port_a_line_seven_oe_n,
    // Pad controls and block results.
    output reg  [3:0] pad_pullup_enable,
    output reg        pad_drive_low,
    output reg        crystal_pin_one,
    output reg        crystal_pin_two,
    output reg        lcd_common_three,
    output reg        comparator_positive_input,
    output reg        comparator_negative_source_four,
    output reg        hardware_reset_pin_n,
    output reg  [3:0] port_in_data,
    output reg        wake_event,
    output reg        sleep_active
);

    // =================================================================
    // Pin input synchronisation
    // =================================================================
    wire [3:0] raw_pins;
    wire [3:0] synced_pins;
    wire [3:0] gated_pins;
    wire [3:0] pin_wake;

    assign raw_pins = {port_a_line_seven_in, port_a_line_six_in,
                       port_a_line_five_in, port_a_line_four_in};

    pin_sync #(
        .WIDTH    (`PIN_COUNT)
    ) u_pin_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (raw_pins),
        .sync_out (synced_pins)
    );

    // A disabled input buffer reads as zero and can never wake the chip.
    assign gated_pins = synced_pins & port_input_enable; // RULE4

    // =================================================================
    // Per-pin wake-up detection
    // =================================================================
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g = g + 1)
        begin : gen_wake
            wake_filter #(
                .NORMAL_CYCLES (WAKE_NORMAL_CYCLES),
                .COUNT_WIDTH   (`WAKE_COUNT_WIDTH)
            ) u_wake_filter (
                .clock         (clock),
                .nrst          (nrst),
                .level         (gated_pins[g]), // RULE11
                .fast          (wake_speed_fast), // RULE9
                .wake          (pin_wake[g])
            );
        end
    endgenerate

    // =================================================================
    // Pin role decode
    // =================================================================
    wire line_four_analog;
    wire crystal_mode;
    wire reset_mode;

    assign crystal_mode     = external_crystal_oscillator;
    assign reset_mode       = hardware_reset_enable;
    assign line_four_analog = lcd_common_three_enable | comparator_positive_select |
                              comparator_negative_select;

    // =================================================================
    // Next pad drive values
    // =================================================================
    reg [3:0] next_out;
    reg [3:0] next_oe_n;

    always @*
    begin
        next_out  = `PORT_RESET_ZERO;
        next_oe_n = `PORT_RESET_ONES;

        // Line four: analog roles release the driver, PWM beats port data.
        if (line_four_analog)
        begin
            next_oe_n[`IDX_LINE_FOUR] = 1'b1; // RULE8
        end
        else if (line_four_pwm_enable)
        begin
            next_out[`IDX_LINE_FOUR]  = pwm_gen_one_output; // RULE12
            next_oe_n[`IDX_LINE_FOUR] = 1'b0; // RULE8
        end
        else
        begin
            next_out[`IDX_LINE_FOUR]  = port_out_data[`IDX_LINE_FOUR]; // RULE1
            next_oe_n[`IDX_LINE_FOUR] = ~port_direction_out[`IDX_LINE_FOUR]; // RULE1
        end

        // Line five never drives high: a one only releases the pin.
        if (reset_mode)
        begin
            next_oe_n[`IDX_LINE_FIVE] = 1'b1; // RULE3
        end
        else if (line_five_pwm_enable)
        begin
            next_oe_n[`IDX_LINE_FIVE] = pwm_gen_two_output; // RULE12
        end
        else if (port_direction_out[`IDX_LINE_FIVE])
        begin
            next_oe_n[`IDX_LINE_FIVE] = port_out_data[`IDX_LINE_FIVE]; // RULE2
        end
        else
        begin
            next_oe_n[`IDX_LINE_FIVE] = 1'b1;
        end

        // Lines six and seven belong to the oscillator in crystal mode.
        if (!crystal_mode)
        begin
            next_out[`IDX_LINE_SIX]    = port_out_data[`IDX_LINE_SIX]; // RULE1
            next_oe_n[`IDX_LINE_SIX]   = ~port_direction_out[`IDX_LINE_SIX]; // RULE1
            next_out[`IDX_LINE_SEVEN]  = port_out_data[`IDX_LINE_SEVEN]; // RULE1
            next_oe_n[`IDX_LINE_SEVEN] = ~port_direction_out[`IDX_LINE_SEVEN]; // RULE1
        end
    end

    // =================================================================
    // Sleep control
    // =================================================================
    wire any_wake;
    reg  next_sleep;

    assign any_wake = |pin_wake;

    // A request made while already asleep is ignored; a change seen while
    // asleep always ends sleep, so no event is lost to a late request.
    always @*
    begin
        next_sleep = sleep_active;
        if (sleep_active && any_wake)
        begin
            next_sleep = 1'b0; // RULE6
        end
        else if (!sleep_active && sleep_request)
        begin
            next_sleep = 1'b1;
        end
    end

    // =================================================================
    // Registered outputs
    // =================================================================
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            port_a_line_four_out            <= `BIT_RESET_ZERO;
            port_a_line_four_oe_n           <= `BIT_RESET_ONE;
            port_a_line_five_out            <= `BIT_RESET_ZERO;
            port_a_line_five_oe_n           <= `BIT_RESET_ONE;
            port_a_line_six_out             <= `BIT_RESET_ZERO;
            port_a_line_six_oe_n            <= `BIT_RESET_ONE;
            port_a_line_seven_out           <= `BIT_RESET_ZERO;
            port_a_line_seven_oe_n          <= `BIT_RESET_ONE;
            pad_pullup_enable               <= `PORT_RESET_ZERO;
            pad_drive_low                   <= `BIT_RESET_ZERO;
            crystal_pin_one                 <= `BIT_RESET_ZERO;
            crystal_pin_two                 <= `BIT_RESET_ZERO;
            lcd_common_three                <= `BIT_RESET_ZERO;
            comparator_positive_input       <= `BIT_RESET_ZERO;
            comparator_negative_source_four <= `BIT_RESET_ZERO;
            hardware_reset_pin_n            <= `BIT_RESET_ONE;
            port_in_data                    <= `PORT_RESET_ZERO;
            wake_event                      <= `BIT_RESET_ZERO;
            sleep_active                    <= `BIT_RESET_ZERO;
        end
        else
        begin
            port_a_line_four_out            <= next_out[`IDX_LINE_FOUR];
            port_a_line_four_oe_n           <= next_oe_n[`IDX_LINE_FOUR];
            port_a_line_five_out            <= next_out[`IDX_LINE_FIVE];
            port_a_line_five_oe_n           <= next_oe_n[`IDX_LINE_FIVE];
            port_a_line_six_out             <= next_out[`IDX_LINE_SIX];
            port_a_line_six_oe_n            <= next_oe_n[`IDX_LINE_SIX];
            port_a_line_seven_out           <= next_out[`IDX_LINE_SEVEN];
            port_a_line_seven_oe_n          <= next_oe_n[`IDX_LINE_SEVEN];
            pad_pullup_enable               <= port_pullup_enable; // RULE11
            pad_drive_low                   <= drive_low_select; // RULE10
            crystal_pin_one                 <= crystal_mode; // RULE7
            crystal_pin_two                 <= crystal_mode; // RULE7
            lcd_common_three                <= lcd_common_three_enable; // RULE8
            comparator_positive_input       <= comparator_positive_select; // RULE8
            comparator_negative_source_four <= comparator_negative_select; // RULE8
            // The reset role reads the raw synchronised pin, not the gated one,
            // so a cleared input enable cannot hide an external reset.
            hardware_reset_pin_n            <= reset_mode ? synced_pins[`IDX_LINE_FIVE]
                                                          : 1'b1; // RULE3
            port_in_data                    <= gated_pins; // RULE4
            wake_event                      <= sleep_active & any_wake; // RULE6
            sleep_active                    <= next_sleep;
        end
    end

endmodule

// ==== port_a_upper_defines.vh ====
`ifndef PORT_A_UPPER_DEFINES_VH
`define PORT_A_UPPER_DEFINES_VH

// =====================================================================
// Pin count and bit positions inside the four-bit upper port vectors
// =====================================================================
`define PIN_COUNT        4
`define IDX_LINE_FOUR    0
`define IDX_LINE_FIVE    1
`define IDX_LINE_SIX     2
`define IDX_LINE_SEVEN   3

// =====================================================================
// Reset values
// =====================================================================
`define PORT_RESET_ZERO  4'h0
`define PORT_RESET_ONES  4'hF
`define BIT_RESET_ZERO   1'h0
`define BIT_RESET_ONE    1'h1

// =====================================================================
// Wake-up filtering
// =====================================================================
`define WAKE_NORMAL_CYCLES 8
`define WAKE_COUNT_WIDTH   4

`endif

// ==== pin_sync.v ====
module pin_sync #(
    parameter WIDTH = 4
) (
    input  wire             clock,
    input  wire             nrst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    // =================================================================
    // Two-stage synchroniser
    // =================================================================
    // The first stage feeds only the second stage.
    reg [WIDTH-1:0] stage_one;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stage_one <= {WIDTH{1'b0}};
            sync_out  <= {WIDTH{1'b0}};
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// ==== wake_filter.v ====
`include "port_a_upper_defines.vh"

module wake_filter #(
    parameter NORMAL_CYCLES = `WAKE_NORMAL_CYCLES,
    parameter COUNT_WIDTH   = `WAKE_COUNT_WIDTH
) (
    input  wire clock,
    input  wire nrst,
    input  wire level,
    input  wire fast,
    output reg  wake
);

    // =================================================================
    // Level change detector with normal and fast speed
    // =================================================================
    // The count is cut to the counter width on purpose; the default fits.
    localparam integer           LAST_INT   = NORMAL_CYCLES - 1;
    localparam [COUNT_WIDTH-1:0] LAST_COUNT = LAST_INT[COUNT_WIDTH-1:0];
    localparam [COUNT_WIDTH-1:0] ONE        = {{(COUNT_WIDTH-1){1'b0}}, 1'b1};

    reg                   primed;
    reg                   last_level;
    reg [COUNT_WIDTH-1:0] stable_count;

    // The reference level is loaded once after reset, but from the synchroniser's reset zero,
    // so a pin that idles high still looks like a change two cycles later.
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            primed       <= 1'b0;
            last_level   <= 1'b0;
            stable_count <= {COUNT_WIDTH{1'b0}};
            wake         <= 1'b0;
        end
        else
        begin
            wake <= 1'b0;
            if (!primed)
            begin
                primed     <= 1'b1;
                last_level <= level;
            end
            else if (level == last_level)
            begin
                stable_count <= {COUNT_WIDTH{1'b0}};
            end
            else if (fast || stable_count == LAST_COUNT)
            begin
                wake         <= 1'b1;
                last_level   <= level;
                stable_count <= {COUNT_WIDTH{1'b0}};
            end
            else
            begin
                stable_count <= stable_count + ONE;
            end
        end
    end

endmodule

// ==== port_a_upper_pin_control_chk.sv ====
module pin_control_chk (
    input logic       clock,
    input logic       nrst,
    input logic [3:0] port_input_enable,
    input logic       drive_low_select,
    input logic       external_crystal_oscillator,
    input logic       hardware_reset_enable,
    input logic       line_five_pwm_enable,
    input logic       sleep_request,
    input logic       pwm_gen_two_output,
    input logic       port_a_line_five_out,
    input logic       port_a_line_five_oe_n,
    input logic       port_a_line_six_oe_n,
    input logic       port_a_line_seven_oe_n,
    input logic       pad_drive_low,
    input logic       crystal_pin_one,
    input logic       hardware_reset_pin_n,
    input logic [3:0] port_in_data,
    input logic       wake_event,
    input logic       sleep_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // =====================================================================
    // Wake-up steps
    // =====================================================================
    sequence s_wake_end;
        !sleep_active ##1 !wake_event;
    endsequence
    sequence s_was_asleep;
        $past(sleep_active);
    endsequence
    // =====================================================================
    // Pin rules
    // =====================================================================
    a_five_open_drain: assert property (!port_a_line_five_out)
        else $error("line five drove a high level");
    a_crystal_release: assert property (external_crystal_oscillator |=>
        crystal_pin_one && port_a_line_six_oe_n && port_a_line_seven_oe_n)
        else $error("crystal mode left a crystal pin driven");
    a_reset_pin_idle: assert property (!hardware_reset_enable |=> hardware_reset_pin_n)
        else $error("reset output active outside reset mode");
    a_five_pwm_path: assert property (line_five_pwm_enable && !hardware_reset_enable
        |=> port_a_line_five_oe_n == $past(pwm_gen_two_output))
        else $error("line five does not follow its PWM source");
    a_input_gated: assert property (1'b1 |=>
        (port_in_data & ~$past(port_input_enable)) == 4'h0)
        else $error("disabled pin reached the input data");
    a_drive_select: assert property (1'b1 |=> pad_drive_low == $past(drive_low_select))
        else $error("drive strength select not passed on");
    a_sleep_entry: assert property (!sleep_active && sleep_request |=> sleep_active)
        else $error("sleep request not taken");
    a_wake_pulse: assert property (wake_event |-> s_wake_end)
        else $error("wake event not a single cycle ending sleep");
    a_wake_cause: assert property (wake_event |-> s_was_asleep)
        else $error("wake event while awake");
endmodule

bind port_a_upper_pin_control pin_control_chk u_chk (
    .clock, .nrst, .port_input_enable, .drive_low_select, .external_crystal_oscillator,
    .hardware_reset_enable, .line_five_pwm_enable, .sleep_request, .pwm_gen_two_output,
    .port_a_line_five_out, .port_a_line_five_oe_n, .port_a_line_six_oe_n,
    .port_a_line_seven_oe_n, .pad_drive_low, .crystal_pin_one, .hardware_reset_pin_n,
    .port_in_data, .wake_event, .sleep_active);

// ==== pin_far_side.sv ====
module pin_far_side (
    input  logic       clock,
    input  logic [3:0] drive_n,
    input  logic [3:0] drive_val,
    input  logic [3:0] pull_en,
    input  logic [3:0] ext_en,
    input  logic [3:0] ext_val,
    output logic [3:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic float_pat = 1'b0;
    // An undriven pin without pull-up wanders, so a stale level never reads back.
    always @(posedge clock) float_pat <= ~float_pat;
    always_comb
        for (int i = 0; i < 4; i++)
            level[i] = !drive_n[i] ? drive_val[i] : ext_en[i] ? ext_val[i] :
                       pull_en[i] ? 1'b1 : float_pat;
endmodule

// ==== port_a_upper_pin_control_bench.sv ====
module port_a_upper_pin_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock, nrst, wsf, dls, eco, hre, p5e, p4e, lce, cps, cns, sreq, pg2, pg1;
    logic [3:0] pod, pdo, ppe, pie, ext_val, ext_en;
    wire  [3:0] pin_in, pin_out, pin_oe_n, pad_pu, pin_data;
    wire        pad_dl, x1, x2, lcd, cmpp, cmpn, rst_n, wake, asleep;
    int         n_errors = 0;
    int         checks_done = 0;

    port_a_upper_pin_control u_dut (
        .clock(clock), .nrst(nrst), .port_out_data(pod), .port_direction_out(pdo),
        .port_pullup_enable(ppe), .port_input_enable(pie), .wake_speed_fast(wsf),
        .drive_low_select(dls), .external_crystal_oscillator(eco),
        .hardware_reset_enable(hre), .line_five_pwm_enable(p5e),
        .line_four_pwm_enable(p4e), .lcd_common_three_enable(lce),
        .comparator_positive_select(cps), .comparator_negative_select(cns),
        .sleep_request(sreq), .pwm_gen_two_output(pg2), .pwm_gen_one_output(pg1),
        .port_a_line_four_in(pin_in[0]), .port_a_line_four_out(pin_out[0]),
        .port_a_line_four_oe_n(pin_oe_n[0]), .port_a_line_five_in(pin_in[1]),
        .port_a_line_five_out(pin_out[1]), .port_a_line_five_oe_n(pin_oe_n[1]),
        .port_a_line_six_in(pin_in[2]), .port_a_line_six_out(pin_out[2]),
        .port_a_line_six_oe_n(pin_oe_n[2]), .port_a_line_seven_in(pin_in[3]),
        .port_a_line_seven_out(pin_out[3]), .port_a_line_seven_oe_n(pin_oe_n[3]),
        .pad_pullup_enable(pad_pu), .pad_drive_low(pad_dl), .crystal_pin_one(x1),
        .crystal_pin_two(x2), .lcd_common_three(lcd), .comparator_positive_input(cmpp),
        .comparator_negative_source_four(cmpn), .hardware_reset_pin_n(rst_n),
        .port_in_data(pin_data), .wake_event(wake), .sleep_active(asleep));

    pin_far_side u_far (.clock(clock), .drive_n(pin_oe_n), .drive_val(pin_out),
        .pull_en(pad_pu), .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));

    // =====================================================================
    // Helpers
    // =====================================================================
    task automatic tick(int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Line five only pulls low: a released high shows what the outside holds.
    function automatic logic [3:0] exp_oe(logic [3:0] d, logic [3:0] dir);
        exp_oe = ~dir | {2'h0, dir[1] & d[1], 1'b0};
    endfunction

    function automatic logic [3:0] exp_level(logic [3:0] d, logic [3:0] dir, logic [3:0] ev);
        exp_level = (dir & d) | (~dir & ev);
        exp_level[1] = dir[1] ? d[1] & ev[1] : ev[1];
    endfunction

    task automatic wake_run(logic fast, int want);
        int n;
        wsf = fast;
        pie = 4'h1;
        ext_val = 4'h0;
        pdo = 4'h0;
        tick(12);
        sreq = 1'b1;
        tick(1);
        sreq = 1'b0;
        check("asleep", 4'h1, {3'h0, asleep});
        ext_val = 4'h2;
        tick(14);
        check("blocked wake", 4'h1, {3'h0, asleep});
        ext_val = 4'h3;
        n = 0;
        while (wake !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        check("wake latency", want[3:0], n[3:0]);
        tick(1);
        check("after wake", 4'h0, {2'h0, wake, asleep});
        $display("test wake speed %0d done", fast);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // =====================================================================
    // Clock, watchdog and tests
    // =====================================================================
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        repeat (3000) @(posedge clock);
        n_errors++;
        $display("unexpected timeout: expected finish seen hang");
        give_verdict();
    end

    initial
    begin
        {pod, pdo, ppe, pie, ext_val} = 20'h0;
        ext_en = 4'hF;
        {wsf, dls, eco, hre, p5e, p4e, lce, cps, cns, sreq, pg2, pg1} = 12'h0;
        nrst = 1'b0;
        void'($urandom(32'h02C3));
        tick(5);
        nrst = 1'b1;
        for (int k = 0; k < 24; k++)
        begin
            {pod, pdo, ppe, pie, ext_val} = 20'($urandom);
            dls = 1'($urandom);
            tick(4);
            check("oe_n", exp_oe(pod, pdo), pin_oe_n);
            check("drive", pod & ~exp_oe(pod, pdo), pin_out & ~pin_oe_n);
            check("in data", exp_level(pod, pdo, ext_val) & pie, pin_data);
            check("pullup", ppe, pad_pu);
            check("drive low", {3'h0, dls}, {3'h0, pad_dl});
        end
        $display("test random port done");
        pod = 4'hF;
        pdo = 4'hF;
        pie = 4'h3;
        eco = 1'b1;
        tick(2);
        check("crystal", 4'hF, {x1, x2, pin_oe_n[3:2]});
        eco = 1'b0;
        hre = 1'b1;
        ext_val = 4'h0;
        tick(4);
        check("reset in", 4'h8, {pin_oe_n[1], rst_n, 2'h0});
        ext_val = 4'hF;
        tick(4);
        check("reset release", 4'h9, {pin_oe_n[1], 2'h0, rst_n});
        hre = 1'b0;
        p5e = 1'b1;
        p4e = 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            pg1 = v[0];
            pg2 = !v[0];
            tick(2);
            check("pwm", {1'b0, pg2, 1'b0, pg1}, {1'b0, pin_oe_n[1:0], pin_out[0]});
        end
        for (int i = 0; i < 3; i++)
        begin
            {lce, cps, cns} = 3'h4 >> i;
            tick(2);
            check("analog", {lce, cps, cns, 1'b1}, {lcd, cmpp, cmpn, pin_oe_n[0]});
        end
        {lce, cps, cns, p4e, p5e} = 5'h0;
        pdo = 4'h0;
        ext_en = 4'h0;
        ppe = 4'h5;
        pie = 4'hF;
        tick(4);
        check("pulled", 4'h5, pin_data & 4'h5);
        ext_en = 4'hF;
        $display("test alternate roles done");
        wake_run(1'b1, 4);
        wake_run(1'b0, 11);
        give_verdict();
    end
endmodule
